// ### logic/dspwm_defs.vh
// Constants for the dual-slope PWM timer: register offsets, fields, modes.
// Assumes an AXI4-Lite master with 32-bit data; included by the timer module.
// Contract
// - Phase correct: overflow flag at BOTTOM
// - Phase correct: A/capture flag at TOP update
// - Fixed TOP masks compare bits on write
// - Phase correct loads compare buffers at TOP
// - Action two non-inverted, three inverted
// - Output reaches pin only when direction set
// - BOTTOM compare low, TOP compare high
// - Mode 11, action 1 toggles A
// - Divisors 1,8,64,256,1024; third adds 16,32
// - Modes 8, 9 are frequency correct
// - Clear on up match, set on down
// - Frequency correct TOP: capture or compare A
// - Hold TOP one tick then reverse
// - Compare flag set on every match
// - Frequency correct: load and overflow at BOTTOM
// - Frequency correct: A/capture flag at TOP
// - Mode 9, action 1 toggles A
// - Counter advances only on timer tick
// - Phase correct TOP sources by mode
// - Compare A writes go to buffer
`ifndef DSPWM_DEFS_VH
`define DSPWM_DEFS_VH
`define DSPWM_CTRL_OFF    8'h00
`define DSPWM_CNT_OFF     8'h04
`define DSPWM_CMPA_OFF    8'h08
`define DSPWM_CMPB_OFF    8'h0c
`define DSPWM_CAPTOP_OFF  8'h10
`define DSPWM_STATUS_OFF  8'h14
`define DSPWM_MODE_LSB    0
`define DSPWM_ACTA_LSB    4
`define DSPWM_ACTB_LSB    6
`define DSPWM_CLK_LSB     8
`define DSPWM_DIRA_BIT    12
`define DSPWM_DIRB_BIT    13
`define DSPWM_CTRL_MASK   32'h0000_3fff
`define DSPWM_ST_OVF      0
`define DSPWM_ST_CMPA     1
`define DSPWM_ST_CMPB     2
`define DSPWM_ST_CAP      3
`define DSPWM_ST_UP       4
`define DSPWM_MODE_PC8    4'h1
`define DSPWM_MODE_PC9    4'h2
`define DSPWM_MODE_PC10   4'h3
`define DSPWM_MODE_PFC_CAP 4'h8
`define DSPWM_MODE_PFC_A  4'h9
`define DSPWM_MODE_PC_CAP 4'ha
`define DSPWM_MODE_PC_A   4'hb
`define DSPWM_TOP8        16'h00ff
`define DSPWM_TOP9        16'h01ff
`define DSPWM_TOP10       16'h03ff
`define DSPWM_MAX         16'hffff
`define DSPWM_RESP_OKAY   2'h0
`define DSPWM_RESP_SLVERR 2'h2
`endif

// ### logic/dspwm_timer.v
// Dual-slope 16-bit PWM timer with two compare channels and AXI4-Lite registers.
// Assumes one 200 MHz clock, synchronous active-high reset, inputs synchronous.
`timescale 1ns/1ps
`include "dspwm_defs.vh"
module dspwm_timer #(
  parameter HAS_EXTRA_DIV = 1'b0
) (
  input  wire        clock,
  input  wire        srst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         waveOutputA,
  output reg         waveOutputAEn,
  output reg         waveOutputB,
  output reg         waveOutputBEn
);
  // Control fields
  reg  [13:0] ctrl;
  wire [3:0]  waveformMode = ctrl[`DSPWM_MODE_LSB +: 4];
  wire [1:0]  outputAActionSelect = ctrl[`DSPWM_ACTA_LSB +: 2];
  wire [1:0]  outputBActionSelect = ctrl[`DSPWM_ACTB_LSB +: 2];
  wire [2:0]  clockSelect = ctrl[`DSPWM_CLK_LSB +: 3];
  wire        pinDirectionA = ctrl[`DSPWM_DIRA_BIT];
  wire        pinDirectionB = ctrl[`DSPWM_DIRB_BIT];

  reg  [15:0] countValue;
  reg         countingUp;
  reg  [15:0] compareAValue;
  reg  [15:0] compareBValue;
  reg  [15:0] compareABuffer;
  reg  [15:0] compareBBuffer;
  reg  [15:0] captureTopValue;
  reg         overflowFlag;
  reg         compareMatchFlagA;
  reg         compareMatchFlagB;
  reg         captureFlag;
  reg  [9:0]  prescaleCount;
  reg         timerTick;

  // Mode decode
  wire isPfc = (waveformMode == `DSPWM_MODE_PFC_CAP) || (waveformMode == `DSPWM_MODE_PFC_A);
  wire isPc  = (waveformMode == `DSPWM_MODE_PC8) || (waveformMode == `DSPWM_MODE_PC9) ||
               (waveformMode == `DSPWM_MODE_PC10) || (waveformMode == `DSPWM_MODE_PC_CAP) ||
               (waveformMode == `DSPWM_MODE_PC_A);
  wire dualSlope = isPc || isPfc;
  wire topFromA = (waveformMode == `DSPWM_MODE_PC_A) || (waveformMode == `DSPWM_MODE_PFC_A);
  wire topFromCap = (waveformMode == `DSPWM_MODE_PC_CAP) ||
                    (waveformMode == `DSPWM_MODE_PFC_CAP);

  // TOP selection per mode
  reg [15:0] topValue;
  reg [15:0] fixedMask;
  always @* begin
    fixedMask = `DSPWM_MAX;
    case (waveformMode)
      `DSPWM_MODE_PC8:  fixedMask = `DSPWM_TOP8;
      `DSPWM_MODE_PC9:  fixedMask = `DSPWM_TOP9;
      `DSPWM_MODE_PC10: fixedMask = `DSPWM_TOP10;
      default:          fixedMask = `DSPWM_MAX;
    endcase
    if (topFromA)
      topValue = compareAValue;
    else if (topFromCap)
      topValue = captureTopValue;
    else
      topValue = fixedMask;
  end

  // Prescaler: divisor select 0 stops the timer
  reg tickDue;
  always @* begin
    case (clockSelect)
      3'h1:    tickDue = 1'b1;
      3'h2:    tickDue = (prescaleCount[2:0] == 3'h7);
      3'h3:    tickDue = (prescaleCount[5:0] == 6'h3f);
      3'h4:    tickDue = (prescaleCount[7:0] == 8'hff);
      3'h5:    tickDue = (prescaleCount == 10'h3ff);
      3'h6:    tickDue = HAS_EXTRA_DIV && (prescaleCount[3:0] == 4'hf);
      3'h7:    tickDue = HAS_EXTRA_DIV && (prescaleCount[4:0] == 5'h1f);
      default: tickDue = 1'b0;
    endcase
  end

  // Free-running prescaler counter and registered tick enable; the register
  // costs one cycle of latency but keeps the divider compare off the count path
  always @(posedge clock) begin
    if (srst) begin
      prescaleCount <= 10'h000;
      timerTick     <= 1'b0;
    end else begin
      prescaleCount <= prescaleCount + 10'h001;
      timerTick     <= tickDue;
    end
  end

  // Events on this tick
  wire atTop    = (countValue == topValue);
  wire atBottom = (countValue == 16'h0000);
  wire matchA   = timerTick && (countValue == compareAValue);
  wire matchB   = timerTick && (countValue == compareBValue);
  wire topEvt   = timerTick && dualSlope && atTop;
  wire botEvt   = timerTick && dualSlope && atBottom;
  wire loadEvt  = isPc ? topEvt : botEvt;

  // Output action per channel; a match follows the slope given by matchUp, not the count direction
  function nextWave;
    input       cur;
    input [1:0] act;
    input       match;
    input       up;
    input       toggleOk;
    begin
      nextWave = cur;
      if (match) begin
        case (act)
          2'h1:    nextWave = toggleOk ? ~cur : cur;
          2'h2:    nextWave = ~up;
          2'h3:    nextWave = up;
          default: nextWave = cur;
        endcase
      end
    end
  endfunction

  // Bus handshake decode
  wire wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awready && s_axi_wready;
  wire wrCtrl = wrFire && (s_axi_awaddr == `DSPWM_CTRL_OFF);
  wire wrCnt  = wrFire && (s_axi_awaddr == `DSPWM_CNT_OFF);
  wire wrCmpA = wrFire && (s_axi_awaddr == `DSPWM_CMPA_OFF);
  wire wrCmpB = wrFire && (s_axi_awaddr == `DSPWM_CMPB_OFF);
  wire wrCap  = wrFire && (s_axi_awaddr == `DSPWM_CAPTOP_OFF);
  wire wrStat = wrFire && (s_axi_awaddr == `DSPWM_STATUS_OFF);
  wire [31:0] clearBits = wrStat ? s_axi_wdata : 32'h0000_0000;
  wire [15:0] maskedWr  = s_axi_wdata[15:0] & fixedMask;

  // Next count and direction; a count write from the bus wins over the tick
  reg [15:0] next_countValue;
  reg        next_countingUp;
  always @* begin
    next_countValue = countValue;
    next_countingUp = countingUp;
    if (wrCnt) begin
      next_countValue = s_axi_wdata[15:0];
    end else if (timerTick && dualSlope) begin
      // TOP holds for the one tick on which it is reached, then the slope turns
      if (atTop) begin
        next_countingUp = 1'b0;
        next_countValue = countValue - 16'h0001;
      end else if (atBottom) begin
        next_countingUp = 1'b1;
        next_countValue = countValue + 16'h0001;
      end else if (countingUp) begin
        next_countValue = countValue + 16'h0001;
      end else begin
        next_countValue = countValue - 16'h0001;
      end
    end
  end

  // Compare values follow their buffers at once outside the dual-slope modes,
  // since there no period exists whose ends a late update could spoil
  wire [15:0] next_compareAValue = wrCmpA ? maskedWr : compareABuffer;
  wire [15:0] next_compareBValue = wrCmpB ? maskedWr : compareBBuffer;
  wire        compareLoad        = loadEvt || !dualSlope;

  // Counter, direction and double buffers; the count and direction advance only on the tick
  always @(posedge clock) begin
    if (srst) begin
      countValue     <= 16'h0000;
      countingUp     <= 1'b1;
      compareAValue  <= 16'h0000;
      compareBValue  <= 16'h0000;
      compareABuffer <= 16'h0000;
      compareBBuffer <= 16'h0000;
    end else begin
      if (wrCmpA)
        compareABuffer <= maskedWr;
      if (wrCmpB)
        compareBBuffer <= maskedWr;
      if (compareLoad) begin
        compareAValue <= next_compareAValue;
        compareBValue <= next_compareBValue;
      end
      countValue <= next_countValue;
      countingUp <= next_countingUp;
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always @(posedge clock) begin
    if (srst) begin
      overflowFlag      <= 1'b0;
      compareMatchFlagA <= 1'b0;
      compareMatchFlagB <= 1'b0;
      captureFlag       <= 1'b0;
    end else begin
      overflowFlag <= botEvt | (overflowFlag & ~clearBits[`DSPWM_ST_OVF]);
      compareMatchFlagA <= matchA | (topFromA & topEvt) |
                           (compareMatchFlagA & ~clearBits[`DSPWM_ST_CMPA]);
      compareMatchFlagB <= matchB | (compareMatchFlagB & ~clearBits[`DSPWM_ST_CMPB]);
      captureFlag <= (topFromCap & topEvt) |
                     (captureFlag & ~clearBits[`DSPWM_ST_CAP]);
    end
  end

  // Slope that a match is judged against. A match at TOP is taken as a
  // down-count and one at BOTTOM as an up-count, so a compare value at either
  // end lands on the level that the turn keeps: under action two low for BOTTOM, high for TOP; under action three the reverse
  wire matchUp = atTop ? 1'b0 : (atBottom ? 1'b1 : countingUp);

  // Per-channel inputs gathered so that one loop serves both channels
  wire [1:0] chanMatch    = {matchB, matchA};
  wire [3:0] chanAction   = {outputBActionSelect, outputAActionSelect};
  wire [1:0] chanToggleOk = {1'b0, topFromA}; // Only channel A may toggle
  wire [1:0] waveLevel;

  // Waveform register per channel; it holds while no dual-slope mode is set
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gen_wave
      reg level;
      always @(posedge clock) begin
        if (srst) begin
          level <= 1'b0;
        end else if (dualSlope) begin
          level <= nextWave(level, chanAction[2 * ch +: 2], chanMatch[ch], matchUp,
                            chanToggleOk[ch]);
        end
      end
      assign waveLevel[ch] = level;
    end
  endgenerate

  // Pin drive gated by direction bit
  always @(posedge clock) begin
    if (srst) begin
      waveOutputA   <= 1'b0;
      waveOutputAEn <= 1'b0;
      waveOutputB   <= 1'b0;
      waveOutputBEn <= 1'b0;
    end else begin
      waveOutputA   <= waveLevel[0];
      waveOutputB   <= waveLevel[1];
      waveOutputAEn <= pinDirectionA && (outputAActionSelect != 2'h0);
      waveOutputBEn <= pinDirectionB && (outputBActionSelect[1]);
    end
  end

  // Control and capture-top registers. The capture TOP is not double buffered:
  // a value written below the running count is missed, and the counter then
  // runs on to the 16-bit end and wraps before it can meet TOP again
  always @(posedge clock) begin
    if (srst) begin
      ctrl            <= 14'h0000;
      captureTopValue <= 16'h0000;
    end else begin
      if (wrCtrl)
        ctrl <= s_axi_wdata[13:0];
      if (wrCap)
        captureTopValue <= s_axi_wdata[15:0]; // Not buffered: takes effect at once
    end
  end

  // AXI write channel: take address and data together, answer one cycle later
  wire wrMapped = (s_axi_awaddr == `DSPWM_CTRL_OFF) || (s_axi_awaddr == `DSPWM_CNT_OFF) ||
                  (s_axi_awaddr == `DSPWM_CMPA_OFF) || (s_axi_awaddr == `DSPWM_CMPB_OFF) ||
                  (s_axi_awaddr == `DSPWM_CAPTOP_OFF) || (s_axi_awaddr == `DSPWM_STATUS_OFF);
  always @(posedge clock) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DSPWM_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !wrFire;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !wrFire;
      if (wrFire) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrMapped ? `DSPWM_RESP_OKAY : `DSPWM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Status word; bit 4 shows the slope so software can tell the half period
  wire [31:0] statusWord = {27'h0,
                            countingUp,        // Bit 4
                            captureFlag,       // Bit 3
                            compareMatchFlagB, // Bit 2
                            compareMatchFlagA, // Bit 1
                            overflowFlag};     // Bit 0

  // AXI read channel: state read back, unmapped answers SLVERR with zero
  reg [31:0] readMux;
  reg        rdMapped;
  always @* begin
    rdMapped = 1'b1;
    case (s_axi_araddr)
      `DSPWM_CTRL_OFF:   readMux = {18'h0, ctrl};
      `DSPWM_CNT_OFF:    readMux = {16'h0000, countValue};
      `DSPWM_CMPA_OFF:   readMux = {16'h0000, compareABuffer};
      `DSPWM_CMPB_OFF:   readMux = {16'h0000, compareBBuffer};
      `DSPWM_CAPTOP_OFF: readMux = {16'h0000, captureTopValue};
      `DSPWM_STATUS_OFF: readMux = statusWord;
      default: begin
        readMux  = 32'h0000_0000;
        rdMapped = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DSPWM_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readMux;
        s_axi_rresp  <= rdMapped ? `DSPWM_RESP_OKAY : `DSPWM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### tb/dspwm_load.sv
// Load on the two waveform pins, as seen from outside the timer.
// Assumes a pull-down on each pin, so a released pin reads low.
`timescale 1ns/1ps
module dspwm_load (
  input  wire logic waveOutputA,
  input  wire logic waveOutputAEn,
  input  wire logic waveOutputB,
  input  wire logic waveOutputBEn,
  output logic      pinA,
  output logic      pinB
);
  // Level reaches the load only while driven; else pull-down wins
  assign pinA = waveOutputAEn ? waveOutputA : 1'h0;
  assign pinB = waveOutputBEn ? waveOutputB : 1'h0;
endmodule

// ### tb/dspwm_timer_asserts.sv
// Port-level checker for the dual-slope timer: bus handshake and pins.
// Assumes it is bound into dspwm_timer; tracks control writes on the bus.
`timescale 1ns/1ps
module dspwm_chk (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        waveOutputA,
  input wire logic        waveOutputAEn,
  input wire logic        waveOutputB,
  input wire logic        waveOutputBEn
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [13:0] ctrlSeen;
  logic [3:0]  stopCnt;
  // Control shadow; lets pin enables be judged without the internals
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlSeen <= 14'h0;
      stopCnt  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00) begin
        ctrlSeen <= s_axi_wdata[13:0];
      end
      stopCnt <= (ctrlSeen[10:8] != 3'h0) ? 4'h0 : stopCnt + {3'h0, stopCnt != 4'hf};
    end
  end
  a_wr_ready_pair: assert property ($rose(s_axi_awready) |-> s_axi_wready)
    else $error("write ready halves apart");
  a_write_taken: assert property ($rose(s_axi_awvalid) && s_axi_wvalid && !s_axi_bvalid
    |-> ##[1:2] (s_axi_awready && s_axi_wready)) else $error("write not taken");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_taken: assert property ($rose(s_axi_arvalid) |-> ##[1:2] s_axi_arready)
    else $error("read not taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_pin_en_a: assert property ($changed(waveOutputAEn) |->
    waveOutputAEn == (ctrlSeen[12] && ctrlSeen[5:4] != 2'h0)) else $error("pin A enable");
  a_pin_en_b: assert property ($changed(waveOutputBEn) |->
    waveOutputBEn == (ctrlSeen[13] && ctrlSeen[7])) else $error("pin B enable");
  a_wave_still: assert property (stopCnt == 4'hf |->
    $stable(waveOutputA) && $stable(waveOutputB)) else $error("wave moved while stopped");
  c_slave_error: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_wave_a: cover property (waveOutputAEn && $changed(waveOutputA));
  c_wave_b: cover property (waveOutputBEn && $changed(waveOutputB));
endmodule
bind dspwm_timer dspwm_chk u_chk (.*);

// ### tb/testbench.sv
// Self-checking bench: register table, waveform runs per mode and divisor.
// Assumes the timer and its checker; the pins feed a pull-down load model.
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [1:0] r; logic [31:0] q;} dspwm_row_t;
  typedef struct {logic [3:0] m; logic [2:0] s; int dv, top, cb;
                  logic [1:0] aa, ab; int ha, hb; logic [3:0] st;} dspwm_run_t;
  logic        clock = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        waveOutputA, waveOutputAEn, waveOutputB, waveOutputBEn, pinA, pinB;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          fail_count = 0, cmp_count = 0, ha, hb;
  // Fixed-TOP rows show the compare masking; the last row is unmapped
  dspwm_row_t rows[10] = '{'{8'h00, 32'h1, 2'h0, 32'h1}, '{8'h08, 32'h1345, 2'h0, 32'h45},
    '{8'h00, 32'h2, 2'h0, 32'h2}, '{8'h0c, 32'hffff, 2'h0, 32'h1ff},
    '{8'h00, 32'h3, 2'h0, 32'h3}, '{8'h08, 32'hffff, 2'h0, 32'h3ff},
    '{8'h00, 32'hf0fb, 2'h0, 32'h30fb}, '{8'h0c, 32'h155, 2'h0, 32'h155},
    '{8'h10, 32'h12345678, 2'h0, 32'h5678}, '{8'h18, 32'h1, 2'h2, 32'h0}};
  // High ticks over ten periods; flag bits overflow, A, B, capture
  dspwm_run_t runs[7] = '{'{4'h9, 3'h1, 1, 7, 3, 2'h1, 2'h2, 70, 60, 4'h7},
    '{4'h9, 3'h2, 8, 7, 3, 2'h1, 2'h3, 70, 80, 4'h7},
    '{4'hb, 3'h6, 16, 7, 0, 2'h1, 2'h2, 70, 0, 4'h7},
    '{4'hb, 3'h7, 32, 7, 7, 2'h1, 2'h2, 70, 140, 4'h7},
    '{4'h8, 3'h1, 1, 7, 7, 2'h2, 2'h3, 140, 0, 4'hf},
    '{4'ha, 3'h1, 1, 7, 0, 2'h2, 2'h3, 140, 140, 4'hf},
    '{4'h1, 3'h1, 1, 255, 64, 2'h2, 2'h2, 140, 1280, 4'h7}};
  dspwm_timer #(.HAS_EXTRA_DIV(1'h1)) dut (.*);
  dspwm_load u_load (.waveOutputA(waveOutputA), .waveOutputAEn(waveOutputAEn),
    .waveOutputB(waveOutputB), .waveOutputBEn(waveOutputBEn), .pinA(pinA), .pinB(pinB));
  always #2.5 clock = ~clock;
  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    check_word(nm, {30'h0, e}, {30'h0, g});
  endtask
  // Bounded wait step; a hang ends the run as a mismatch
  task automatic bump(inout int n);
    @(negedge clock);
    n++;
    if (n > 200) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] w, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do bump(n); while (s_axi_awready !== 1'h1);
    @(posedge clock);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h1;
    do bump(n); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do bump(n); while (s_axi_arready !== 1'h1);
    @(posedge clock);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do bump(n); while (s_axi_rvalid !== 1'h1);
    q = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    logic [1:0] rs;
    axi_write(a, w, rs);
    check_resp("bresp", 2'h0, rs);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      axi_read(8'(i * 4), d, r);
      // Status shows the counter set to count up after reset
      check_word("reset value", (i == 5) ? 32'h10 : 32'h0, d);
    end
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].w, r);
      check_resp("write resp", rows[i].r, r);
      axi_read(rows[i].a, d, r);
      check_resp("read resp", rows[i].r, r);
      check_word("readback", rows[i].q, d);
    end
    // Preload while stopped and non dual-slope so compares copy at once
    foreach (runs[i]) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h7);
      wr(8'h10, 32'h7);
      wr(8'h0c, runs[i].cb);
      wr(8'h14, 32'hf);
      wr(8'h00, {18'h0, 2'h3, 1'h0, runs[i].s, runs[i].ab, runs[i].aa, runs[i].m});
      repeat (4 * runs[i].top * runs[i].dv + 20) @(posedge clock);
      ha = 0;
      hb = 0;
      repeat (20 * runs[i].top * runs[i].dv) begin
        @(negedge clock);
        ha += pinA;
        hb += pinB;
      end
      check_word("high A", runs[i].ha * runs[i].dv, ha);
      check_word("high B", runs[i].hb * runs[i].dv, hb);
      @(posedge clock);
      wr(8'h00, 32'h0);
      axi_read(8'h14, d, r);
      check_word("flags", {28'h0, runs[i].st}, d & 32'hf);
    end
    // Actions set but direction bits low keep both pins released
    wr(8'h00, 32'h199);
    repeat (40) @(posedge clock);
    check_word("enables", 32'h0, {30'h0, waveOutputAEn, waveOutputBEn});
    wr(8'h00, 32'h1199);
    repeat (40) @(posedge clock);
    check_word("enables", 32'h2, {30'h0, waveOutputAEn, waveOutputBEn});
    srst <= 1'h1;
    repeat (3) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    axi_read(8'h00, d, r);
    check_word("control after reset", 32'h0, d);
    give_verdict();
  end
endmodule
